/* hdl/cpu_int_regs.vh */
// Register map, field positions, reset values and counts of the
// interrupt controller. Included by the controller; definitions only.
`ifndef CPU_INT_REGS_VH
`define CPU_INT_REGS_VH

// Printed register indices; the APB byte address is four times these
`define IDX_CONTROL      8'h00
`define IDX_STATUS       8'h01
`define IDX_PRI_POINTER  8'h02
`define IDX_HIGH_VECTOR  8'h03
`define ADDR_CONTROL     12'h000
`define ADDR_STATUS      12'h004
`define ADDR_PRI_POINTER 12'h008
`define ADDR_HIGH_VECTOR 12'h00C

// Control fields
`define CTRL_ROTATE_BIT   0
`define CTRL_COMPACT_BIT  5
`define CTRL_VECSEL_BIT   6
`define CTRL_RESET        8'h00

// Status fields
`define STAT_NORMAL_BIT   0
`define STAT_HIGH_BIT     1
`define STAT_UNMASK_BIT   7
`define STAT_RESET        8'h00

`define PTR_RESET         8'h00
`define HVEC_RESET        8'h00
`define HVEC_NONE         8'h00

// Vector map: vector 0 is reset, vector 1 the non-maskable source
`define NUM_VECTORS       32
`define VEC_NMI           5'h01

// Compact table slots
`define SLOT_NMI          8'h01
`define SLOT_HIGH         8'h02
`define SLOT_NORMAL       8'h03

// Protected-write window, in CPU instructions after the key
`define UNLOCK_INSTR      3'h4

`endif

/* hdl/cpu_interrupt_controller_ctrl.v */
// Control, status and priority logic of the CPU interrupt controller,
// with an APB register slave. Assumes request lines, the global enable,
// acknowledge, return and instruction strobes come from CPU-clock logic.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "cpu_int_regs.vh"

module cpu_interrupt_controller_ctrl (
  input  wire        clk,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Core side
  input  wire [31:0] irqRequest,
  input  wire        globalEnable,
  input  wire        irqAck,
  input  wire        interruptReturn,
  input  wire        ioRegisterKey,
  input  wire        instrDone,
  input  wire        bootWholeFlash,
  input  wire [15:0] bootSectionEnd,
  output wire        irqValid,
  output wire [7:0]  irqVecNum,
  output wire [15:0] irqVecAddr,
  output wire [7:0]  activeLevels
);

  localparam [2:0] LVL_NONE   = 3'b001;
  localparam [2:0] LVL_NORMAL = 3'b010;
  localparam [2:0] LVL_HIGH   = 3'b100;

  // Registers
  reg        rotatingPriorityEnable_reg;
  reg        compactTableEnable_reg;
  reg        vectorLocationSelect_reg;
  reg [7:0]  normalPriorityPointer_reg;
  reg [7:0]  highPriorityVectorNumber_reg;
  reg        unmaskableActiveFlag_reg;
  reg        highLevelActiveFlag_reg;
  reg        normalLevelActiveFlag_reg;
  reg [2:0]  unlockCount_reg;
  reg [31:0] prdata_reg;
  reg        pready_reg;
  reg        pslverr_reg;
  reg        irqValid_reg;
  reg [7:0]  irqVecNum_reg;
  reg [15:0] irqVecAddr_reg;
  reg [2:0]  presentLevel_reg;

  reg [2:0]  unlockCount_next;
  reg [7:0]  normalPriorityPointer_next;
  reg        unmaskable_next;
  reg        highLevel_next;
  reg        normalLevel_next;
  reg [31:0] readValue;
  reg        addrHit;
  reg        candValid;
  reg [7:0]  candNum;
  reg [2:0]  candLevel;
  reg [7:0]  candSlot;
  reg [15:0] vectorBase;

  wire        apbDone   = psel & penable & pready_reg;
  wire        apbWrite  = apbDone & pwrite;
  wire        unlockOpen = (unlockCount_reg != 3'h0);
  wire [31:0] highMask;
  wire [31:0] normalReq;
  wire [4:0]  normalWinner;
  wire        normalAny;
  wire        ackTaken;
  wire        nmiBusy;
  wire        highBusy;
  wire        normalBusy;
  wire        highSelected;

  // Decodes a byte address into a register slot; used for read and write
  function [1:0] regSlot;
    input [11:0] addr;
    begin
      regSlot = addr[3:2];
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr[11:4] == 8'h00) && (addr[1:0] == 2'b00);
    end
  endfunction

  // First request found walking upward from one above the pointer
  function [5:0] firstFromPointer;
    input [31:0] req;
    input [4:0]  ptr;
    integer      i;
    reg   [4:0]  idx;
    reg          found;
    begin
      firstFromPointer = 6'h00;
      found = 1'b0;
      for (i = 1; i <= `NUM_VECTORS; i = i + 1) begin
        idx = ptr + i[4:0];
        if (!found && req[idx]) begin
          found = 1'b1;
          firstFromPointer = {1'b1, idx};
        end
      end
    end
  endfunction

  // Acknowledge of a presented request at one given level
  function levelTaken;
    input       taken;
    input [2:0] present;
    input [2:0] level;
    begin
      levelTaken = taken && (present == level);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `NUM_VECTORS; g = g + 1) begin : gMask
      assign highMask[g] = (highPriorityVectorNumber_reg == g) &&
                           (highPriorityVectorNumber_reg != `HVEC_NONE);
    end
  endgenerate

  // Reset and the unmaskable vector never compete at level 0
  assign normalReq = irqRequest & ~highMask & 32'hFFFFFFFC;
  assign {normalAny, normalWinner} =
    firstFromPointer(normalReq, normalPriorityPointer_reg[4:0]);

  // A request taken at this edge already counts as executing, so the
  // cycle after an acknowledge never shows the same vector again
  assign ackTaken   = irqAck & irqValid_reg;
  assign nmiBusy    = unmaskableActiveFlag_reg |
                      levelTaken(ackTaken, presentLevel_reg, LVL_NONE);
  assign highBusy   = highLevelActiveFlag_reg |
                      levelTaken(ackTaken, presentLevel_reg, LVL_HIGH);
  assign normalBusy = normalLevelActiveFlag_reg |
                      levelTaken(ackTaken, presentLevel_reg, LVL_NORMAL);

  // Level 1 is off for vector zero or a number beyond the map
  assign highSelected =
    (highPriorityVectorNumber_reg != `HVEC_NONE) &&
    (highPriorityVectorNumber_reg < 8'h20) &&
    irqRequest[highPriorityVectorNumber_reg[4:0]];

  // APB read mux
  always @* begin
    readValue = 32'h00000000;
    addrHit   = mapped(paddr);
    case (regSlot(paddr))
      2'h0: begin
        readValue[`CTRL_ROTATE_BIT]  = rotatingPriorityEnable_reg;
        readValue[`CTRL_COMPACT_BIT] = compactTableEnable_reg;
        readValue[`CTRL_VECSEL_BIT]  = vectorLocationSelect_reg;
      end
      2'h1: begin
        readValue[`STAT_UNMASK_BIT] = unmaskableActiveFlag_reg;
        readValue[`STAT_HIGH_BIT]   = highLevelActiveFlag_reg;
        readValue[`STAT_NORMAL_BIT] = normalLevelActiveFlag_reg;
      end
      2'h2: readValue[7:0] = normalPriorityPointer_reg;
      2'h3: readValue[7:0] = highPriorityVectorNumber_reg;
      default: readValue = 32'h00000000;
    endcase
    if (!addrHit) begin
      readValue = 32'h00000000;
    end
  end

  // Unlock window: opened by the key, counts down per instruction
  always @* begin
    unlockCount_next = unlockCount_reg;
    // The protected write uses up the window; a second one needs a new key
    if (ioRegisterKey) begin
      unlockCount_next = `UNLOCK_INSTR;
    end else if (apbWrite && addrHit && regSlot(paddr) == 2'h0) begin
      unlockCount_next = 3'h0;
    end else if (instrDone && unlockOpen) begin
      unlockCount_next = unlockCount_reg - 3'h1;
    end
  end

  // Arbitration: unmaskable, then level 1, then level 0
  always @* begin
    candValid = 1'b0;
    candNum   = 8'h00;
    candLevel = LVL_NONE;
    if (irqRequest[`VEC_NMI] && !nmiBusy) begin
      candValid = 1'b1;
      candNum   = {3'b000, `VEC_NMI};
    end else if (!nmiBusy && !highBusy && globalEnable &&
                 highSelected) begin
      candValid = 1'b1;
      candNum   = highPriorityVectorNumber_reg;
      candLevel = LVL_HIGH;
    end else if (!nmiBusy && !highBusy && !normalBusy &&
                 globalEnable && normalAny) begin
      candValid = 1'b1;
      candNum   = {3'b000, normalWinner};
      candLevel = LVL_NORMAL;
    end
  end

  // Vector slot and placement
  always @* begin
    candSlot = candNum;
    if (compactTableEnable_reg) begin
      case (candLevel)
        LVL_HIGH:   candSlot = `SLOT_HIGH;
        LVL_NORMAL: candSlot = `SLOT_NORMAL;
        default:    candSlot = `SLOT_NMI;
      endcase
    end
    // Whole-flash boot puts the table at the boot start regardless
    if (bootWholeFlash || vectorLocationSelect_reg) begin
      vectorBase = 16'h0000;
    end else begin
      vectorBase = bootSectionEnd;
    end
  end

  // Executing-level tracking and pointer update
  always @* begin
    unmaskable_next  = unmaskableActiveFlag_reg;
    highLevel_next   = highLevelActiveFlag_reg;
    normalLevel_next = normalLevelActiveFlag_reg;
    normalPriorityPointer_next = normalPriorityPointer_reg;
    if (apbWrite && addrHit && regSlot(paddr) == 2'h2) begin
      normalPriorityPointer_next = pwdata[7:0];
    end
    // A return unwinds only the innermost level, so earlier state stays
    if (interruptReturn) begin
      if (unmaskableActiveFlag_reg) begin
        unmaskable_next = 1'b0;
      end else if (highLevelActiveFlag_reg) begin
        highLevel_next = 1'b0;
      end else begin
        normalLevel_next = 1'b0;
      end
    end
    // Entering a handler wins over a return in the same cycle
    if (ackTaken) begin
      case (presentLevel_reg)
        LVL_HIGH:   highLevel_next = 1'b1;
        LVL_NORMAL: begin
          normalLevel_next = 1'b1;
          // The vector just taken drops to the lowest priority
          if (rotatingPriorityEnable_reg) begin
            normalPriorityPointer_next = irqVecNum_reg;
          end
        end
        default:    unmaskable_next = 1'b1;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rotatingPriorityEnable_reg   <= 1'b0;
      compactTableEnable_reg       <= 1'b0;
      vectorLocationSelect_reg     <= 1'b0;
      normalPriorityPointer_reg    <= `PTR_RESET;
      highPriorityVectorNumber_reg <= `HVEC_RESET;
      unmaskableActiveFlag_reg     <= 1'b0;
      highLevelActiveFlag_reg      <= 1'b0;
      normalLevelActiveFlag_reg    <= 1'b0;
      unlockCount_reg              <= 3'h0;
      prdata_reg                   <= 32'h00000000;
      pready_reg                   <= 1'b0;
      pslverr_reg                  <= 1'b0;
      irqValid_reg                 <= 1'b0;
      irqVecNum_reg                <= 8'h00;
      irqVecAddr_reg               <= 16'h0000;
      presentLevel_reg             <= LVL_NONE;
    end else begin
      // No wait state: ready rises in the first access cycle
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~addrHit;
      if (psel && !penable && !pwrite) begin
        prdata_reg <= readValue;
      end
      if (apbWrite && addrHit) begin
        case (regSlot(paddr))
          2'h0: begin
            rotatingPriorityEnable_reg <= pwdata[`CTRL_ROTATE_BIT];
            if (unlockOpen) begin
              compactTableEnable_reg   <= pwdata[`CTRL_COMPACT_BIT];
              vectorLocationSelect_reg <= pwdata[`CTRL_VECSEL_BIT];
            end
          end
          2'h3: highPriorityVectorNumber_reg <= pwdata[7:0];
          default: ;
        endcase
      end
      unlockCount_reg           <= unlockCount_next;
      normalPriorityPointer_reg <= normalPriorityPointer_next;
      unmaskableActiveFlag_reg  <= unmaskable_next;
      highLevelActiveFlag_reg   <= highLevel_next;
      normalLevelActiveFlag_reg <= normalLevel_next;
      irqValid_reg     <= candValid;
      irqVecNum_reg    <= candNum;
      presentLevel_reg <= candLevel;
      irqVecAddr_reg   <= vectorBase + {8'h00, candSlot};
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign irqValid     = irqValid_reg;
  assign irqVecNum    = irqVecNum_reg;
  assign irqVecAddr   = irqVecAddr_reg;
  assign activeLevels = {unmaskableActiveFlag_reg, 5'b00000,
                         highLevelActiveFlag_reg, normalLevelActiveFlag_reg};

endmodule // cpu_interrupt_controller_ctrl

/* dv/cpu_int_ctrl_asserts.sv */
// Port checker for the interrupt controller, bound to its top module.
// Assumes one clock, async active-low reset, core strobes one cycle wide.
`timescale 1ns/1ps
module cpu_int_ctrl_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        irqAck,
  input wire logic        interruptReturn,
  input wire logic [31:0] irqRequest,
  input wire logic        irqValid,
  input wire logic [7:0]  irqVecNum,
  input wire logic [7:0]  activeLevels
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_nmi_ack;
    irqAck && irqValid && irqVecNum == 8'h01;
  endsequence
  property p_ready_next;
    s_setup |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("ready missing after setup");
  property p_ready_once;
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready longer than one cycle");
  property p_nmi_set;
    s_nmi_ack |=> activeLevels[7];
  endproperty
  a_nmi_set: assert property (p_nmi_set)
    else $error("unmaskable flag not set on accept");
  property p_nmi_block;
    $past(activeLevels[7]) |-> !irqValid;
  endproperty
  a_nmi_block: assert property (p_nmi_block)
    else $error("request presented during unmaskable handler");
  property p_high_only_nmi;
    $past(activeLevels[1]) && irqValid |-> irqVecNum == 8'h01;
  endproperty
  a_high_only_nmi: assert property (p_high_only_nmi)
    else $error("lower request presented during high handler");
  property p_high_hold;
    activeLevels[1] && !(interruptReturn && !activeLevels[7])
      |=> activeLevels[1];
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("high flag lost without its return");
  property p_norm_hold;
    activeLevels[0] &&
      !(interruptReturn && !activeLevels[7] && !activeLevels[1])
      |=> activeLevels[0];
  endproperty
  a_norm_hold: assert property (p_norm_hold)
    else $error("normal flag lost without its return");
  property p_ret_inner;
    interruptReturn && !irqAck && activeLevels[7] |=>
      !activeLevels[7] && activeLevels[1:0] == $past(activeLevels[1:0]);
  endproperty
  a_ret_inner: assert property (p_ret_inner)
    else $error("return did not restore the earlier levels");
  property p_nmi_present;
    irqRequest[1] && !activeLevels[7] && !irqAck
      |=> irqValid && irqVecNum == 8'h01;
  endproperty
  a_nmi_present: assert property (p_nmi_present)
    else $error("unmaskable request not presented");
  property p_ack_retire;
    irqAck && irqValid |=> !(irqValid && irqVecNum == $past(irqVecNum));
  endproperty
  a_ack_retire: assert property (p_ack_retire)
    else $error("accepted vector presented again");
endmodule // cpu_int_ctrl_asserts

bind cpu_interrupt_controller_ctrl cpu_int_ctrl_asserts u_chk (.*);

/* dv/cpu_core_model.sv */
// Behavioural CPU core: accepts presented vectors, issues returns.
// Assumes the bench asks for returns; acceptance can be slowed down.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic irqValid,
  input  wire logic takeEn,
  input  wire logic slow,
  input  wire logic retReq,
  output logic      irqAck,
  output logic      interruptReturn,
  output logic      instrDone
);
  logic [2:0] holdOff;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {irqAck, interruptReturn, instrDone} <= 3'h0;
      holdOff <= 3'h0;
    end else begin
      instrDone       <= ~instrDone;
      interruptReturn <= retReq;
      irqAck          <= 1'b0;
      // Hold-off covers the cycle where the presented vector is stale
      if (holdOff != 3'h0)
        holdOff <= holdOff - 3'h1;
      else if (takeEn && irqValid) begin
        irqAck  <= 1'b1;
        holdOff <= slow ? 3'h7 : 3'h2;
      end
    end
  end
endmodule // cpu_core_model

/* dv/test_cpu_interrupt_controller_ctrl.sv */
// Self-checking bench for the interrupt controller control block.
// Assumes the core model acknowledges presented vectors on its own.
`timescale 1ns/1ps
`include "cpu_int_regs.vh"
module test_cpu_interrupt_controller_ctrl;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, slv;
  logic        globalEnable, irqAck, interruptReturn, ioRegisterKey;
  logic        instrDone, bootWholeFlash, irqValid, takeEn, slow, retReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, irqRequest, rnd, rd;
  logic [15:0] bootSectionEnd, irqVecAddr, base;
  logic [7:0]  irqVecNum, activeLevels;
  logic [23:0] expQ[$];
  int          n_fail, checks_done, cyc;

  cpu_interrupt_controller_ctrl DUT (.*);
  cpu_core_model core (.*);

  always #2 clk = ~clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check("register", rd, {24'h000000, e});
  endtask

  task automatic unlock();
    @(posedge clk);
    ioRegisterKey <= 1'b1;
    @(posedge clk);
    ioRegisterKey <= 1'b0;
  endtask

  task automatic ask(input logic [31:0] m, input logic [7:0] v,
                     input logic [15:0] a);
    expQ.push_back({v, a});
    irqRequest <= irqRequest | m;
  endtask

  task automatic drain();
    while (expQ.size() != 0) @(posedge clk);
    @(posedge clk);
  endtask

  task automatic ret();
    retReq <= 1'b1;
    @(posedge clk);
    retReq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Watches accepted vectors; the handler clears its source flag
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      report_and_stop();
    end
    if (irqAck && irqValid) begin
      if (expQ.size() == 0)
        check("unasked accept", {24'h0, irqVecNum}, 32'hFFFFFFFF);
      else
        check("vector", {irqVecNum, irqVecAddr}, expQ.pop_front());
      irqRequest[irqVecNum[4:0]] <= 1'b0;
    end
  end

  initial begin
    {clk, nrst, psel, penable, pwrite, ioRegisterKey, retReq, slow} = 8'h00;
    {bootWholeFlash, globalEnable, takeEn} = 3'b011;
    {paddr, pwdata, irqRequest} = '0;
    // Nonzero so that select bit 1 visibly moves the table to zero
    bootSectionEnd = 16'h0400;
    {n_fail, checks_done, cyc} = '0;
    rnd = 32'h8C5B;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
      rdchk(12'(4 * i), 8'h00);
    apb(1'b0, 12'h010, 8'h00);
    check("slverr", {31'h0, slv}, 32'h1);
    apb(1'b1, `ADDR_STATUS, 8'h83);
    rdchk(`ADDR_STATUS, 8'h00);
    apb(1'b1, `ADDR_CONTROL, 8'h61);
    rdchk(`ADDR_CONTROL, 8'h01);
    unlock();
    apb(1'b1, `ADDR_CONTROL, 8'h61);
    rdchk(`ADDR_CONTROL, 8'h61);
    unlock();
    repeat (12) @(posedge clk);
    apb(1'b1, `ADDR_CONTROL, 8'h00);
    rdchk(`ADDR_CONTROL, 8'h60);
    $display("register test done");
    apb(1'b1, `ADDR_HIGH_VECTOR, 8'h14);
    ask(32'h2, 8'h01, 16'h0001);
    drain();
    ret();
    ask(32'h100000, 8'h14, 16'h0002);
    drain();
    ret();
    ask(32'h40, 8'h06, 16'h0003);
    drain();
    ret();
    $display("compact test done");
    rnd = xs(rnd);
    base = rnd[15:0] & 16'hFFC0;
    bootSectionEnd <= base;
    unlock();
    apb(1'b1, `ADDR_CONTROL, 8'h00);
    ask(32'h210, 8'h04, base + 16'h4);
    drain();
    ask(32'h100000, 8'h14, base + 16'h14);
    drain();
    rdchk(`ADDR_STATUS, 8'h03);
    ask(32'h2, 8'h01, base + 16'h1);
    drain();
    rdchk(`ADDR_STATUS, 8'h83);
    ret();
    rdchk(`ADDR_STATUS, 8'h03);
    ret();
    rdchk(`ADDR_STATUS, 8'h01);
    check("blocked", {31'h0, irqValid}, 32'h0);
    ask(32'h0, 8'h09, base + 16'h9);
    ret();
    drain();
    ret();
    apb(1'b1, `ADDR_PRI_POINTER, 8'h09);
    ask(32'h1200, 8'h0C, base + 16'hC);
    drain();
    rdchk(`ADDR_PRI_POINTER, 8'h09);
    ask(32'h0, 8'h09, base + 16'h9);
    ret();
    drain();
    ret();
    $display("fixed priority test done");
    apb(1'b1, `ADDR_PRI_POINTER, 8'h00);
    apb(1'b1, `ADDR_CONTROL, 8'h01);
    slow <= 1'b1;
    ask(32'h88, 8'h03, base + 16'h3);
    drain();
    rdchk(`ADDR_PRI_POINTER, 8'h03);
    ask(32'h0, 8'h07, base + 16'h7);
    ret();
    drain();
    ret();
    bootWholeFlash <= 1'b1;
    apb(1'b1, `ADDR_HIGH_VECTOR, 8'h00);
    rnd = xs(rnd);
    ask(32'h1 << (rnd[3:0] + 2), 8'(rnd[3:0] + 2), 16'(rnd[3:0] + 2));
    drain();
    irqRequest <= irqRequest | 32'h100000;
    repeat (8) @(posedge clk);
    check("level one off", {31'h0, irqValid}, 32'h0);
    ask(32'h0, 8'h14, 16'h0014);
    ret();
    drain();
    ret();
    $display("rotating and boot test done");
    report_and_stop();
  end
endmodule // test_cpu_interrupt_controller_ctrl
